// ---- core/port_caps_pkg.sv ----
package port_caps_pkg;

	// Bus geometry
	localparam int ADDR_W = 12;
	localparam int DATA_W = 32;
	localparam int STRB_W = 4;

	// Register indices; byte address is four times the index
	localparam logic [ADDR_W-1:0] IDX_DEV_CONTROL = 12'h048;
	localparam logic [ADDR_W-1:0] IDX_DEV_STATUS = 12'h04A;
	localparam logic [ADDR_W-1:0] IDX_LINK_CAPS = 12'h04C;
	localparam logic [ADDR_W-1:0] IDX_LINK_CONTROL = 12'h050;
	localparam logic [ADDR_W-1:0] IDX_IRQ_MASK = 12'h0F0;
	localparam logic [ADDR_W-1:0] ADDR_DEV_CONTROL = {IDX_DEV_CONTROL[ADDR_W-3:0], 2'h0};
	localparam logic [ADDR_W-1:0] ADDR_DEV_STATUS = {IDX_DEV_STATUS[ADDR_W-3:0], 2'h0};
	localparam logic [ADDR_W-1:0] ADDR_LINK_CAPS = {IDX_LINK_CAPS[ADDR_W-3:0], 2'h0};
	localparam logic [ADDR_W-1:0] ADDR_LINK_CONTROL = {IDX_LINK_CONTROL[ADDR_W-3:0], 2'h0};
	localparam logic [ADDR_W-1:0] ADDR_IRQ_MASK = {IDX_IRQ_MASK[ADDR_W-3:0], 2'h0};

	// Bus responses
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// Device control upper: read request size
	localparam int RRS_LSB = 12;
	localparam logic [2:0] RRS_VALUE = 3'h0;

	// Device status flags
	localparam int N_FLAGS = 4;
	localparam int FLAG_CORR = 0;
	localparam int FLAG_NONFATAL = 1;
	localparam int FLAG_FATAL = 2;
	localparam int FLAG_UNSUP = 3;
	localparam logic [N_FLAGS-1:0] FLAGS_RESET = 4'h0;
	localparam logic [N_FLAGS-1:0] MASK_RESET = 4'h0;

	// Link capabilities fields
	localparam int SPEED_LSB = 0;
	localparam int WIDTH_LSB = 4;
	localparam int WIDTH_W = 6;
	localparam int ASPM_LSB = 10;
	localparam int L0S_LSB = 12;
	localparam int L1_LSB = 15;
	localparam int REFCLK_RM_BIT = 18;
	localparam int SURPRISE_BIT = 19;
	localparam int DLLA_BIT = 20;
	localparam int BW_NOTIFY_BIT = 21;
	localparam logic [3:0] SPEED_2G5 = 4'h1;
	localparam logic [3:0] SPEED_5G = 4'h2;
	localparam logic [1:0] ASPM_L0S_L1 = 2'h3;
	localparam logic [2:0] L0S_SEPARATE = 3'h5;
	localparam logic [2:0] L0S_COMMON = 3'h3;
	localparam logic [2:0] L1_RESET = 3'h2;
	localparam logic REFCLK_RM_RESET = 1'h0;

	// Link width codes
	localparam int N_WIDTH_CODES = 7;
	localparam logic [WIDTH_W-1:0] WIDTH_X1 = 6'h01;
	localparam logic [WIDTH_W-1:0] WIDTH_CODES [N_WIDTH_CODES] = '{6'h01, 6'h02, 6'h04, 6'h08, 6'h0C, 6'h0D, 6'h20};

	// Link control
	localparam int SHARED_CLK_BIT = 6;

endpackage

// ---- core/sticky_flag_bank.sv ----
module sticky_flag_bank (
	input wire logic mclk,
	input wire logic srst,
	input wire logic [port_caps_pkg::N_FLAGS-1:0] set_evt,
	input wire logic [port_caps_pkg::N_FLAGS-1:0] clr,
	output logic [port_caps_pkg::N_FLAGS-1:0] flags
);
	import port_caps_pkg::*;

	genvar i;
	generate
		for (i = 0; i < N_FLAGS; i++) begin : g_flag
			// A new event beats a clear in the same cycle
			always_ff @(posedge mclk) begin
				if (srst) begin
					flags[i] <= FLAGS_RESET[i];
				end else begin
					flags[i] <= set_evt[i] | (flags[i] & ~clr[i]);
				end
			end
		end
	endgenerate

endmodule // sticky_flag_bank

// ---- core/link_width_decode.sv ----
module link_width_decode (
	input wire logic [port_caps_pkg::WIDTH_W-1:0] code,
	output logic [port_caps_pkg::WIDTH_W-1:0] width,
	output logic valid
);
	import port_caps_pkg::*;

	logic [N_WIDTH_CODES-1:0] match;

	genvar i;
	generate
		for (i = 0; i < N_WIDTH_CODES; i++) begin : g_code
			assign match[i] = (code == WIDTH_CODES[i]);
		end
	endgenerate

	assign valid = |match;
	assign width = valid ? code : WIDTH_X1;

endmodule // link_width_decode

// ---- core/port_status_link_caps.sv ----
// Summary of operation
// - The read request size field in device control reads as zero and ignores writes.
// - Correctable, non-fatal and fatal error flags in status bits 0 to 2 are sticky and clear on write-one.
// - Status bit 3 sets on an unsupported request and clears only when software writes one to it.
// - Error flags are logged regardless of any reporting enable.
// - Status bits 4 and 5 (aux power, pending transactions) read as constant zero.
// - The top link speed field reads 0x1, meaning 2.5 Gbps only.
// - Link width starts at the physical lane count, may be lowered, and an invalid code trains as x1.
// - Width codes 1, 2, 4, 8, 12, 13, 32 mean x1, x2, x4, x8, x12, x16, x32; code 0 is reserved.
// - The low power support field reads constant 0x3 for L0s and L1.
// - L1 exit latency defaults to 0x2.
// - Reference clock removal capability defaults to zero.
// - Surprise down capability defaults to 1 downstream and 0 upstream.
// - Link active reporting capability defaults to 1 downstream and 0 upstream.
// - Bandwidth notification defaults to 1 downstream, 0 upstream, and 0 everywhere in 1.1 mode.
// - The shared reference clock bit in link control selects which L0s latency is reported.
module port_status_link_caps (
	input wire logic mclk,
	input wire logic srst,
	// Straps, caught while reset is held
	input wire logic downstream_port,
	input wire logic compat_1p1_mode,
	input wire logic [port_caps_pkg::WIDTH_W-1:0] phys_lane_count,
	// Error events, one-cycle pulses
	input wire logic corr_err_evt,
	input wire logic nonfatal_err_evt,
	input wire logic fatal_err_evt,
	input wire logic unsup_req_evt,
	// AXI4-Lite slave
	input wire logic [port_caps_pkg::ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [port_caps_pkg::DATA_W-1:0] s_axi_wdata,
	input wire logic [port_caps_pkg::STRB_W-1:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [port_caps_pkg::ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [port_caps_pkg::DATA_W-1:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// Toward the link layer
	output logic [port_caps_pkg::WIDTH_W-1:0] link_width_target,
	output logic shared_refclk_config,
	output logic irq
);
	import port_caps_pkg::*;

	// Bus slave handshake state
	logic aw_held;
	logic w_held;
	logic ar_held;
	logic [ADDR_W-1:0] aw_addr_q;
	logic [ADDR_W-1:0] ar_addr_q;
	logic [DATA_W-1:0] wdata_q;
	logic [STRB_W-1:0] wstrb_q;
	logic wr_en;
	logic rd_en;
	logic [DATA_W-1:0] rd_data;
	logic wr_ok;
	logic rd_ok;
	// Handshake strobes, one per channel event
	logic aw_take;
	logic w_take;
	logic ar_take;
	logic b_done;
	logic r_done;

	// Register state
	logic [N_FLAGS-1:0] err_flags;
	logic [N_FLAGS-1:0] irq_mask;
	logic [WIDTH_W-1:0] top_link_width;
	logic [2:0] l1_exit_latency;
	logic refclk_removal_capable;
	logic surprise_down_capable;
	logic link_active_report_capable;
	logic bandwidth_notify_capable;

	// Decode and composed read values
	logic [DATA_W-1:0] wr_mask;
	logic hit_wr_dev_control;
	logic hit_wr_dev_status;
	logic hit_wr_link_caps;
	logic hit_wr_link_control;
	logic hit_wr_irq_mask;
	logic [N_FLAGS-1:0] flag_set;
	logic [N_FLAGS-1:0] flag_clr;
	logic [DATA_W-1:0] dev_control_rd;
	logic [DATA_W-1:0] dev_status_rd;
	logic [DATA_W-1:0] link_caps_rd;
	logic [DATA_W-1:0] link_control_rd;
	logic [DATA_W-1:0] irq_mask_rd;
	logic [DATA_W-1:0] next_link_caps;
	logic [DATA_W-1:0] next_link_control;
	logic [DATA_W-1:0] next_irq_mask;
	logic [2:0] l0s_exit_latency;
	logic [WIDTH_W-1:0] next_link_width_target;
	logic next_irq;
	logic [2:0] read_request_size_limit;
	logic aux_power_present;
	logic pending_transactions_flag;
	logic [3:0] top_link_speed;
	logic [1:0] low_power_support;

	localparam int LANE_W = DATA_W / STRB_W;

	// AXI4-Lite write channel
	// Address and data are taken in either order; the write fires once both are held.
	// Ready stays low until the response is taken, so the held copies cannot be overwritten.
	assign aw_take = s_axi_awvalid & s_axi_awready;
	assign w_take = s_axi_wvalid & s_axi_wready;
	assign b_done = s_axi_bvalid & s_axi_bready;
	assign wr_en = aw_held & w_held & ~s_axi_bvalid;

	always_ff @(posedge mclk) begin
		if (srst) begin
			s_axi_awready <= 1'b1;
			s_axi_wready <= 1'b1;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= RESP_OKAY;
			aw_held <= 1'b0;
			w_held <= 1'b0;
			aw_addr_q <= '0;
			wdata_q <= '0;
			wstrb_q <= '0;
		end else begin
			if (aw_take) begin
				aw_held <= 1'b1;
				aw_addr_q <= s_axi_awaddr;
				s_axi_awready <= 1'b0;
			end
			if (w_take) begin
				w_held <= 1'b1;
				wdata_q <= s_axi_wdata;
				wstrb_q <= s_axi_wstrb;
				s_axi_wready <= 1'b0;
			end
			if (wr_en) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= wr_ok ? RESP_OKAY : RESP_SLVERR;
			end
			if (b_done) begin
				s_axi_bvalid <= 1'b0;
				aw_held <= 1'b0;
				w_held <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready <= 1'b1;
			end
		end
	end

	// AXI4-Lite read channel
	// Reads have no side effects, so the data is sampled a single cycle after the address.
	assign ar_take = s_axi_arvalid & s_axi_arready;
	assign r_done = s_axi_rvalid & s_axi_rready;
	assign rd_en = ar_held & ~s_axi_rvalid;

	always_ff @(posedge mclk) begin
		if (srst) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid <= 1'b0;
			s_axi_rresp <= RESP_OKAY;
			s_axi_rdata <= '0;
			ar_held <= 1'b0;
			ar_addr_q <= '0;
		end else begin
			if (ar_take) begin
				ar_held <= 1'b1;
				ar_addr_q <= s_axi_araddr;
				s_axi_arready <= 1'b0;
			end
			if (rd_en) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rdata <= rd_data;
				s_axi_rresp <= rd_ok ? RESP_OKAY : RESP_SLVERR;
			end
			if (r_done) begin
				s_axi_rvalid <= 1'b0;
				ar_held <= 1'b0;
				s_axi_arready <= 1'b1;
			end
		end
	end

	// Address decode
	genvar lane;
	generate
		for (lane = 0; lane < STRB_W; lane++) begin : g_lane
			// Each strobe bit opens one byte lane of the write data
			assign wr_mask[lane*LANE_W +: LANE_W] = {LANE_W{wstrb_q[lane]}};
		end
	endgenerate
	assign hit_wr_dev_control = wr_en && (aw_addr_q == ADDR_DEV_CONTROL);
	assign hit_wr_dev_status = wr_en && (aw_addr_q == ADDR_DEV_STATUS);
	assign hit_wr_link_caps = wr_en && (aw_addr_q == ADDR_LINK_CAPS);
	assign hit_wr_link_control = wr_en && (aw_addr_q == ADDR_LINK_CONTROL);
	assign hit_wr_irq_mask = wr_en && (aw_addr_q == ADDR_IRQ_MASK);
	assign wr_ok = hit_wr_dev_control | hit_wr_dev_status | hit_wr_link_caps
		| hit_wr_link_control | hit_wr_irq_mask;

	always_comb begin
		rd_data = '0;
		rd_ok = 1'b1;
		if (ar_addr_q == ADDR_DEV_CONTROL) begin
			rd_data = dev_control_rd;
		end else if (ar_addr_q == ADDR_DEV_STATUS) begin
			rd_data = dev_status_rd;
		end else if (ar_addr_q == ADDR_LINK_CAPS) begin
			rd_data = link_caps_rd;
		end else if (ar_addr_q == ADDR_LINK_CONTROL) begin
			rd_data = link_control_rd;
		end else if (ar_addr_q == ADDR_IRQ_MASK) begin
			rd_data = irq_mask_rd;
		end else begin
			rd_ok = 1'b0;
		end
	end

	// Device control, upper half
	// Only whole-size transfers are ever made, so a request size limit has nothing to steer.
	// The lower control bits live elsewhere and read as zero here.
	assign read_request_size_limit = RRS_VALUE;
	assign dev_control_rd = {{(DATA_W-RRS_LSB-$bits(read_request_size_limit)){1'h0}},
		read_request_size_limit, {RRS_LSB{1'h0}}};

	// Device status
	// Events are logged with no reference to any reporting enable.
	assign flag_set[FLAG_CORR] = corr_err_evt;
	assign flag_set[FLAG_NONFATAL] = nonfatal_err_evt;
	assign flag_set[FLAG_FATAL] = fatal_err_evt;
	assign flag_set[FLAG_UNSUP] = unsup_req_evt;
	assign flag_clr = hit_wr_dev_status ? (wdata_q[N_FLAGS-1:0] & wr_mask[N_FLAGS-1:0]) : '0;

	sticky_flag_bank u_flags (
		.mclk(mclk),
		.srst(srst),
		.set_evt(flag_set),
		.clr(flag_clr),
		.flags(err_flags)
	);

	// No aux supply is drawn and no request starts here, so both bits are tied low
	assign aux_power_present = 1'h0;
	assign pending_transactions_flag = 1'h0;
	assign dev_status_rd = {{(DATA_W-N_FLAGS-2){1'h0}}, pending_transactions_flag, aux_power_present, err_flags};

	// Interrupt mask
	assign irq_mask_rd = {{(DATA_W-N_FLAGS){1'b0}}, irq_mask};
	assign next_irq_mask = (irq_mask_rd & ~wr_mask) | (wdata_q & wr_mask);

	always_ff @(posedge mclk) begin
		if (srst) begin
			irq_mask <= MASK_RESET;
		end else if (hit_wr_irq_mask) begin
			irq_mask <= next_irq_mask[N_FLAGS-1:0];
		end
	end

	assign next_irq = |(err_flags & irq_mask);

	always_ff @(posedge mclk) begin
		if (srst) begin
			irq <= 1'b0;
		end else begin
			irq <= next_irq;
		end
	end

	// Link control
	// Only the shared reference clock bit is held in this slice.
	assign link_control_rd = {{(DATA_W-SHARED_CLK_BIT-1){1'h0}}, shared_refclk_config, {SHARED_CLK_BIT{1'h0}}};
	assign next_link_control = (link_control_rd & ~wr_mask) | (wdata_q & wr_mask);

	always_ff @(posedge mclk) begin
		if (srst) begin
			shared_refclk_config <= 1'b0;
		end else if (hit_wr_link_control) begin
			shared_refclk_config <= next_link_control[SHARED_CLK_BIT];
		end
	end

	// Link capabilities
	// A shared reference clock shortens the L0s exit, so the latency follows that bit.
	assign l0s_exit_latency = shared_refclk_config ? L0S_COMMON : L0S_SEPARATE;
	// Fixed fields are plain wires, so a write to them has nowhere to land
	assign top_link_speed = SPEED_2G5;
	assign low_power_support = ASPM_L0S_L1;

	assign link_caps_rd = {
		{(DATA_W-BW_NOTIFY_BIT-1){1'h0}},
		bandwidth_notify_capable,
		link_active_report_capable,
		surprise_down_capable,
		refclk_removal_capable,
		l1_exit_latency,
		l0s_exit_latency,
		low_power_support,
		top_link_width,
		top_link_speed
	};
	assign next_link_caps = (link_caps_rd & ~wr_mask) | (wdata_q & wr_mask);

	// Straps are sampled while reset is held so the defaults match the port's role.
	always_ff @(posedge mclk) begin
		if (srst) begin
			top_link_width <= phys_lane_count;
			l1_exit_latency <= L1_RESET;
			refclk_removal_capable <= REFCLK_RM_RESET;
			surprise_down_capable <= downstream_port;
			link_active_report_capable <= downstream_port;
			bandwidth_notify_capable <= downstream_port & ~compat_1p1_mode;
		end else if (hit_wr_link_caps) begin
			// Speed, low power support and L0s latency are not stored: writes to them fall away
			top_link_width <= next_link_caps[WIDTH_LSB +: WIDTH_W];
			l1_exit_latency <= next_link_caps[L1_LSB +: 3];
			refclk_removal_capable <= next_link_caps[REFCLK_RM_BIT];
			surprise_down_capable <= next_link_caps[SURPRISE_BIT];
			link_active_report_capable <= next_link_caps[DLLA_BIT];
			bandwidth_notify_capable <= next_link_caps[BW_NOTIFY_BIT];
		end
	end

	// Raw width reads back as written; only the trained target is cleaned up.
	link_width_decode u_width (
		.code(top_link_width),
		.width(next_link_width_target),
		.valid()
	);

	always_ff @(posedge mclk) begin
		if (srst) begin
			link_width_target <= WIDTH_X1;
		end else begin
			link_width_target <= next_link_width_target;
		end
	end

endmodule // port_status_link_caps

// ---- test/port_caps_assertions.sv ----
module port_caps_checker (
	input wire logic mclk,
	input wire logic srst,
	input wire logic [port_caps_pkg::ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_rvalid,
	input wire logic [port_caps_pkg::DATA_W-1:0] s_axi_rdata,
	input wire logic [1:0] s_axi_rresp,
	input wire logic [port_caps_pkg::WIDTH_W-1:0] link_width_target,
	input wire logic shared_refclk_config
);
	import port_caps_pkg::*;
	logic [ADDR_W-1:0] last_araddr;
	logic mapped;
	logic rd_new;
	// Address of the read in flight, so answers can be tied to it
	assign mapped = last_araddr inside {ADDR_DEV_CONTROL, ADDR_DEV_STATUS, ADDR_LINK_CAPS, ADDR_LINK_CONTROL, ADDR_IRQ_MASK};
	always_ff @(posedge mclk) begin
		if (srst) begin
			last_araddr <= '0;
		end else if (s_axi_arvalid && s_axi_arready) begin
			last_araddr <= s_axi_araddr;
		end
	end
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (srst);
	AST_DEVCTL_ZERO: assert property ($rose(s_axi_rvalid) && last_araddr == ADDR_DEV_CONTROL |->
		s_axi_rdata == '0)
		else $error("device control word not zero");
	AST_STATUS_FIXED: assert property ($rose(s_axi_rvalid) && last_araddr == ADDR_DEV_STATUS |->
		s_axi_rdata[31:4] == '0)
		else $error("status upper bits not zero");
	AST_CAPS_FIXED: assert property ($rose(s_axi_rvalid) && last_araddr == ADDR_LINK_CAPS |->
		s_axi_rdata[3:0] == SPEED_2G5 && s_axi_rdata[11:10] == ASPM_L0S_L1 && s_axi_rdata[31:22] == '0)
		else $error("link caps constant fields wrong");
	// Read data is captured one edge before rvalid is seen, so the config bit is taken from then
	AST_L0S_SELECT: assert property ($rose(s_axi_rvalid) && last_araddr == ADDR_LINK_CAPS |->
		s_axi_rdata[14:12] == ($past(shared_refclk_config) ? L0S_COMMON : L0S_SEPARATE))
		else $error("l0s latency not matching clock config");
	AST_UNMAPPED: assert property ($rose(s_axi_rvalid) && !mapped |->
		s_axi_rresp == RESP_SLVERR && s_axi_rdata == '0)
		else $error("unmapped read answered wrongly");
	AST_RD_LATENCY: assert property (s_axi_arvalid && s_axi_arready |-> ##[1:2] s_axi_rvalid)
		else $error("read answer late");
	AST_WR_LATENCY: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##[1:3] s_axi_bvalid)
		else $error("write answer late");
	AST_WIDTH_LEGAL: assert property (link_width_target inside {6'h01, 6'h02, 6'h04, 6'h08, 6'h0C, 6'h0D, 6'h20})
		else $error("width target not a legal code");
	cover property ($rose(s_axi_rvalid) && last_araddr == ADDR_LINK_CAPS && shared_refclk_config);
	cover property ($rose(s_axi_rvalid) && !mapped);
	cover property (link_width_target == 6'h20);
endmodule // port_caps_checker

bind port_status_link_caps port_caps_checker port_caps_checker_inst (.mclk(mclk), .srst(srst),
	.s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
	.s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
	.s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid), .s_axi_rvalid(s_axi_rvalid),
	.s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .link_width_target(link_width_target),
	.shared_refclk_config(shared_refclk_config));

// ---- test/testbench.sv ----
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	import port_caps_pkg::*;
	logic mclk, srst, downstream_port, compat_1p1_mode, shared_refclk_config, irq;
	logic [WIDTH_W-1:0] phys_lane_count, link_width_target;
	logic corr_err_evt, nonfatal_err_evt, fatal_err_evt, unsup_req_evt;
	logic [ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
	logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
	logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic [DATA_W-1:0] s_axi_wdata, s_axi_rdata;
	logic [STRB_W-1:0] s_axi_wstrb;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic [33:0] rd_q[$];
	logic [1:0] wr_q[$];
	logic [31:0] seed = 32'h143;
	logic [31:0] rnd;
	logic [5:0] codes [11] = '{6'h01, 6'h02, 6'h04, 6'h08, 6'h0C, 6'h0D, 6'h20, 6'h00, 6'h03, 6'h10, 6'h3F};
	int errors = 0;
	int check_count = 0;
	int cycles = 0;
	port_status_link_caps port_status_link_caps_inst (
		.mclk(mclk), .srst(srst), .downstream_port(downstream_port), .compat_1p1_mode(compat_1p1_mode),
		.phys_lane_count(phys_lane_count), .corr_err_evt(corr_err_evt), .nonfatal_err_evt(nonfatal_err_evt),
		.fatal_err_evt(fatal_err_evt), .unsup_req_evt(unsup_req_evt), .s_axi_awaddr(s_axi_awaddr),
		.s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
		.s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
		.s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
		.s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
		.s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
		.s_axi_rready(s_axi_rready), .link_width_target(link_width_target),
		.shared_refclk_config(shared_refclk_config), .irq(irq));
	initial begin
		mclk = 0;
		forever #20 mclk = ~mclk;
	end
	function automatic logic [31:0] next_rand();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	function automatic logic [31:0] caps(input logic [5:0] w, input logic [2:0] l0s, input logic ds, input logic cm);
		return {10'h000, ds & ~cm, ds, ds, REFCLK_RM_RESET, L1_RESET, l0s, ASPM_L0S_L1, w, SPEED_2G5};
	endfunction
	task automatic compare(input logic [33:0] exp, input logic [33:0] got);
		check_count++;
		if (got !== exp) begin
			errors++;
			$display("unexpected at %0t: expected %h got %h", $time, exp, got);
		end
	endtask
	task automatic compare_resp(input logic [1:0] exp, input logic [1:0] got);
		compare(34'(exp), 34'(got));
	endtask
	task automatic compare_level(input logic [5:0] exp, input logic [5:0] got);
		compare(34'(exp), 34'(got));
	endtask
	task automatic conclude();
		$display("comparisons %0d mismatches %0d", check_count, errors);
		if (errors == 0 && check_count > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask
	task automatic axi_write(input logic [ADDR_W-1:0] a, input logic [31:0] d, input logic [1:0] resp = RESP_OKAY);
		bit aw_done, w_done;
		wr_q.push_back(resp);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'h1;
		s_axi_wvalid <= 1'h1;
		s_axi_bready <= 1'h1;
		aw_done = 0;
		w_done = 0;
		while (!(aw_done && w_done)) begin
			@(posedge mclk);
			if (s_axi_awvalid && s_axi_awready) begin
				aw_done = 1;
				s_axi_awvalid <= 1'h0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_done = 1;
				s_axi_wvalid <= 1'h0;
			end
		end
		do @(posedge mclk); while (!s_axi_bvalid);
		s_axi_bready <= 1'h0;
		@(posedge mclk);
	endtask
	task automatic axi_read(input logic [ADDR_W-1:0] a, input logic [31:0] d, input logic [1:0] resp = RESP_OKAY);
		rd_q.push_back({resp, d});
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'h1;
		s_axi_rready <= 1'h1;
		do @(posedge mclk); while (!s_axi_arready);
		s_axi_arvalid <= 1'h0;
		do @(posedge mclk); while (!s_axi_rvalid);
		s_axi_rready <= 1'h0;
		@(posedge mclk);
	endtask
	task automatic pulse(input logic [3:0] e);
		{unsup_req_evt, fatal_err_evt, nonfatal_err_evt, corr_err_evt} <= e;
		@(posedge mclk);
		{unsup_req_evt, fatal_err_evt, nonfatal_err_evt, corr_err_evt} <= 4'h0;
		repeat (2) @(posedge mclk);
	endtask
	task automatic do_reset(input logic ds, input logic cm, input logic [5:0] lanes);
		srst <= 1'h1;
		downstream_port <= ds;
		compat_1p1_mode <= cm;
		phys_lane_count <= lanes;
		repeat (4) @(posedge mclk);
		srst <= 1'h0;
		@(posedge mclk);
	endtask
	// Results are judged here, in arrival order, against what the drivers queued
	always @(posedge mclk) begin
		if (s_axi_rvalid && s_axi_rready) compare(rd_q.pop_front(), {s_axi_rresp, s_axi_rdata});
		if (s_axi_bvalid && s_axi_bready) compare_resp(wr_q.pop_front(), s_axi_bresp);
		cycles++;
		if (cycles == 5000) begin
			errors++;
			conclude();
		end
	end
	initial begin
		{srst, downstream_port, compat_1p1_mode, phys_lane_count} = '0;
		{corr_err_evt, nonfatal_err_evt, fatal_err_evt, unsup_req_evt} = '0;
		{s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wvalid, s_axi_bready} = '0;
		{s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
		s_axi_wstrb = 4'hF;
		do_reset(1'h1, 1'h0, 6'h08);
		axi_read(ADDR_LINK_CAPS, caps(6'h08, L0S_SEPARATE, 1'h1, 1'h0));
		compare_level(link_width_target, 6'h08);
		repeat (3) axi_write(ADDR_DEV_CONTROL, next_rand());
		axi_read(ADDR_DEV_CONTROL, 32'h0);
		$display("reset values and read size done");
		for (int i = 0; i < 4; i++) begin
			pulse(4'(1 << i));
			axi_read(ADDR_DEV_STATUS, 32'((2 << i) - 1));
		end
		rnd = next_rand();
		axi_write(ADDR_DEV_STATUS, {rnd[31:4], 4'h5});
		axi_read(ADDR_DEV_STATUS, 32'h0000000A);
		compare_level(6'(irq), 6'h00);
		axi_write(ADDR_IRQ_MASK, 32'h00000002);
		repeat (2) @(posedge mclk);
		compare_level(6'(irq), 6'h01);
		axi_write(ADDR_DEV_STATUS, 32'h00000002);
		repeat (2) @(posedge mclk);
		compare_level(6'(irq), 6'h00);
		pulse(4'h8);
		compare_level(6'(irq), 6'h00);
		axi_read(ADDR_DEV_STATUS, 32'h00000008);
		$display("status flags and interrupt done");
		axi_write(ADDR_LINK_CONTROL, 32'hFFFFFFFF);
		axi_read(ADDR_LINK_CONTROL, 32'h00000040);
		compare_level(6'(shared_refclk_config), 6'h01);
		axi_read(ADDR_LINK_CAPS, caps(6'h08, L0S_COMMON, 1'h1, 1'h0));
		axi_write(ADDR_LINK_CONTROL, 32'h0);
		axi_write(12'h200, 32'hFFFFFFFF, RESP_SLVERR);
		axi_read(12'h200, 32'h0, RESP_SLVERR);
		$display("clock config and unmapped done");
		for (int i = 0; i < 11; i++) begin
			axi_write(ADDR_LINK_CAPS, caps(codes[i], L0S_SEPARATE, 1'h1, 1'h0));
			axi_read(ADDR_LINK_CAPS, caps(codes[i], L0S_SEPARATE, 1'h1, 1'h0));
			compare_level(link_width_target, (i < 7) ? codes[i] : WIDTH_X1);
		end
		$display("width codes done");
		do_reset(1'h0, 1'h0, 6'h04);
		axi_read(ADDR_LINK_CAPS, caps(6'h04, L0S_SEPARATE, 1'h0, 1'h0));
		do_reset(1'h1, 1'h1, 6'h02);
		axi_read(ADDR_LINK_CAPS, caps(6'h02, L0S_SEPARATE, 1'h1, 1'h1));
		axi_read(ADDR_DEV_STATUS, 32'h0);
		$display("strap variants done");
		conclude();
	end
endmodule // testbench
